/* standby_wake_reset_control_tb.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench for swrc_top
// Assumes: core model pulses instrDone while coreRun is high
// Notes: one task per scenario
module standby_wake_reset_control_tb
    import swrc_pkg::*;
;
    logic clk, nrst, wr, rd, instrDone, coreRun, vectorReq, pcLoad;
    logic [3:0] addr, irqSet;
    logic [7:0] wdata, rdata;
    logic [10:0] programCounter;
    int badCount, cmpCount;

    swrc_top #(.NSRC(4)) u_swrc_top (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irqSet(irqSet), .instrDone(instrDone),
        .coreRun(coreRun), .vectorReq(vectorReq), .pcLoad(pcLoad),
        .programCounter(programCounter));
    swrc_core_model u_swrc_core_model (.clk(clk), .nrst(nrst), .coreRun(coreRun),
        .instrDone(instrDone));

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input logic [10:0] got, input logic [10:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wrReg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task rdReg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk({3'h0, rdata}, {3'h0, e});
    endtask
    task pulseIrq(input logic [3:0] m);
        @(posedge clk);
        irqSet <= m;
        @(posedge clk);
        irqSet <= 4'h0;
    endtask
    // bounded wait; running out ends the run
    task waitRun;
        for (int i = 0; i < 20 && coreRun !== 1'h1; i++)
            @(posedge clk) #1;
        chk({10'h0, coreRun}, 11'h001);
        if (coreRun !== 1'h1)
            summarize;
    endtask
    task holdCheck(input logic e);
        repeat (10) @(posedge clk);
        #1;
        chk({10'h0, coreRun}, {10'h0, e});
    endtask
    task watchVec(input logic e);
        logic seen;
        seen = 1'h0;
        repeat (30)
        begin
            @(posedge clk) #1;
            seen = seen | vectorReq;
        end
        chk({10'h0, seen}, {10'h0, e});
    endtask
    task doReset;
        @(posedge clk);
        nrst <= 1'h0;
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk) #1;
        chk({9'h0, pcLoad, coreRun}, 11'h003);
        chk(programCounter, 11'h5a7);
    endtask
    task sleep(input logic [3:0] en, input logic [7:0] ctrl);
        wrReg(OFS_IRQ_REQ, 8'h00);
        wrReg(OFS_IRQ_EN, {4'h0, en});
        wrReg(OFS_CTRL, ctrl);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task sNormalReset;
        wrReg(OFS_VEC_HI, 8'h05);
        wrReg(OFS_VEC_LO, 8'ha7);
        wrReg(OFS_SER_MODE, 8'ha5);
        wrReg(OFS_SER_BUS, 8'h3c);
        doReset;
        rdReg(OFS_SER_MODE, 8'h00);
        rdReg(OFS_SER_BUS, 8'h00);
        rdReg(OFS_PC, 8'ha7);
    endtask
    task sStopReset;
        wrReg(OFS_SER_MODE, 8'h5c);
        wrReg(OFS_SER_BUS, 8'h81);
        wrReg(OFS_SLAVE_ADR, 8'h5a);
        wrReg(OFS_SER_SHIFT, 8'hc3);
        wrReg(OFS_CORE_FLAGS, 8'h1f);
        sleep(4'hf, 8'h04);
        pulseIrq(4'hf);
        holdCheck(1'h0);
        rdReg(OFS_CTRL, 8'h04);
        rdReg(OFS_STATUS, 8'h04);
        doReset;
        rdReg(OFS_SER_MODE, 8'h00);
        rdReg(OFS_SER_BUS, 8'h00);
        rdReg(OFS_SLAVE_ADR, 8'h5a);
        rdReg(OFS_SER_SHIFT, 8'hc3);
        rdReg(OFS_CORE_FLAGS, 8'h01);
        rdReg(OFS_IRQ_REQ, 8'h00);
    endtask
    task sHaltInline;
        sleep(4'h4, 8'h02);
        holdCheck(1'h0);
        pulseIrq(4'h4);
        waitRun;
        watchVec(1'h0);
        rdReg(OFS_IRQ_REQ, 8'h04);
    endtask
    task sHaltVector;
        sleep(4'h4, 8'h03);
        pulseIrq(4'h4);
        waitRun;
        watchVec(1'h1);
    endtask
    task sTestableWake;
        sleep(4'h2, 8'h03);
        pulseIrq(4'h2);
        waitRun;
        watchVec(1'h0);
    endtask
    task sPendingHalt;
        wrReg(OFS_IRQ_EN, 8'h04);
        wrReg(OFS_IRQ_REQ, 8'h04);
        wrReg(OFS_CTRL, 8'h02);
        repeat (6) @(posedge clk);
        #1;
        chk({10'h0, coreRun}, 11'h001);
    endtask
    task sEdgeZero;
        sleep(4'h1, 8'h03);
        pulseIrq(4'h1);
        holdCheck(1'h0);
        doReset;
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        badCount = 0;
        cmpCount = 0;
        nrst = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        addr = 4'h0;
        wdata = 8'h00;
        irqSet = 4'h0;
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        sNormalReset;
        sStopReset;
        sHaltInline;
        sHaltVector;
        sTestableWake;
        sPendingHalt;
        sEdgeZero;
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        badCount++;
        summarize;
    end
endmodule

bind swrc_top swrc_top_sva #(.NSRC(NSRC)) u_swrc_top_sva (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irqSet(irqSet),
    .instrDone(instrDone), .coreRun(coreRun), .vectorReq(vectorReq), .pcLoad(pcLoad),
    .programCounter(programCounter));

/* swrc_core_model.sv */
`timescale 1ns/1ps
// Purpose: behavioural core on the far side of the controller
// Assumes: one instruction ends every second cycle while running
// Notes: ends an instruction only in a cycle that follows one with coreRun high, so vector counts stay honest
module swrc_core_model
    import swrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // core handshake
    input wire logic coreRun,
    output logic instrDone
);
    // ------------------------------------------------------------
    // instruction pacing
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            instrDone <= 1'h0;
        else
            instrDone <= coreRun && !instrDone;
    end
endmodule

/* swrc_pkg.sv */
// Purpose: shared constants and carriers for the standby, wake and reset controller
// Assumes: one 20 MHz clock, synchronous active-low system reset nrst
// Notes: register map reached over a plain strobe port
//
// Overview of operation
// RULE1: reset out of standby equals ordinary reset
// RULE2: halt wake with master enable clear resumes inline
// RULE3: master enable set vectors two instructions later
// RULE4: testable wake input never vectors
// RULE5: reset pin low holds system reset
// RULE6: release loads counter from vectors 000H, 001H
// RULE7: any reset clears serial operation mode
// RULE8: any reset clears serial bus control
// RULE9: standby reset keeps slave address register
// RULE10: standby reset keeps serial shift register
// RULE11: stop ends only by reset
// RULE12: enabled request wakes halt, except edge zero
// RULE13: no stabilisation wait after standby reset
// RULE14: pending enabled request ends halt at once
// RULE15: standby reset keeps carry, clears skip, status
package swrc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_IRQ_REQ = 4'h2;
    localparam logic [3:0] OFS_IRQ_EN = 4'h3;
    localparam logic [3:0] OFS_SER_MODE = 4'h4;
    localparam logic [3:0] OFS_SER_BUS = 4'h5;
    localparam logic [3:0] OFS_SLAVE_ADR = 4'h6;
    localparam logic [3:0] OFS_SER_SHIFT = 4'h7;
    localparam logic [3:0] OFS_PC = 4'h8;
    localparam logic [3:0] OFS_CORE_FLAGS = 4'h9;
    localparam logic [3:0] OFS_VEC_HI = 4'ha;
    localparam logic [3:0] OFS_VEC_LO = 4'hb;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_IME_BIT = 0;
    localparam int CTRL_HALT_BIT = 1;
    localparam int CTRL_STOP_BIT = 2;
    localparam int CTRL_INSTR_BIT = 3;
    localparam int FLAG_CARRY_BIT = 0;
    localparam int IRQ_EDGE0_BIT = 0;
    localparam int IRQ_TWAKE_BIT = 1;
    localparam logic [7:0] SER_MODE_RST = 8'h00;
    localparam logic [7:0] SER_BUS_RST = 8'h00;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [2:0] VEC_HI_RST = 3'h0;
    localparam logic [7:0] VEC_LO_RST = 8'h00;
    localparam logic [1:0] VECTOR_DELAY = 2'h2;

    typedef enum {RUN, HALTED, STOPPED, WAKE_WAIT} swrc_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } swrc_bus_t;

    typedef struct packed {
        logic run;
        logic vectorReq;
        logic [10:0] pc;
        logic pcLoad;
    } swrc_core_t;

endpackage

/* swrc_regfile.sv */
`timescale 1ns/1ps
// Purpose: serial interface registers with standby-aware reset
// Assumes: nrst is synchronous and active low
// Notes: undefined-after-reset contents are modelled as untouched
module swrc_regfile
    import swrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // writes
    input wire logic wrMode,
    input wire logic wrBus,
    input wire logic wrAdr,
    input wire logic wrShift,
    input wire logic [7:0] wdata,
    // contents
    output logic [7:0] serialModeReg,
    output logic [7:0] serialBusReg,
    output logic [7:0] slaveAdrReg,
    output logic [7:0] serialShiftReg
);

    // ------------------------------------------------------------
    // cleared on every reset
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            serialModeReg <= SER_MODE_RST; // RULE7
            serialBusReg <= SER_BUS_RST; // RULE8
        end
        else
        begin
            if (wrMode)
                serialModeReg <= wdata;
            if (wrBus)
                serialBusReg <= wdata;
        end
    end

    // ------------------------------------------------------------
    // retained through reset
    // ------------------------------------------------------------
    // no reset branch: standby reset must keep these, and an
    // operating reset may leave them anything, so holding is legal
    always_ff @(posedge clk)
    begin
        if (nrst && wrAdr)
            slaveAdrReg <= wdata; // RULE9
        if (nrst && wrShift)
            serialShiftReg <= wdata; // RULE10
    end
endmodule

/* swrc_top.sv */
`timescale 1ns/1ps
// Purpose: standby, wake and system reset controller for a small core
// Assumes: nrst is the reset pin, already synchronous
// Notes: core signals come straight from flip-flops
module swrc_top
    import swrc_pkg::*;
#(
    parameter int NSRC = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // interrupt sources, one-cycle set pulses
    input wire logic [NSRC-1:0] irqSet,
    // core handshake
    input wire logic instrDone,
    output logic coreRun,
    output logic vectorReq,
    output logic pcLoad,
    output logic [10:0] programCounter
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    swrc_state_t state_reg, state_next;
    logic ime_reg;
    logic [NSRC-1:0] irqReq_reg;
    logic [NSRC-1:0] irqEn_reg;
    logic [2:0] vecHi_reg;
    logic [7:0] vecLo_reg;
    logic [10:0] pc_reg;
    logic pcLoad_reg;
    logic run_reg;
    logic vecReq_reg;
    logic [1:0] instrCnt_reg;
    logic standby_reg;
    logic relDone_reg;
    logic carry_reg;
    logic [2:0] skip_reg;
    logic status_reg;
    logic [7:0] rdata_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    swrc_bus_t busReq;

    assign busReq = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    wire wrCtrl = busReq.wr && busReq.addr == OFS_CTRL;
    wire wrReq = busReq.wr && busReq.addr == OFS_IRQ_REQ;
    wire wrEn = busReq.wr && busReq.addr == OFS_IRQ_EN;
    wire wrMode = busReq.wr && busReq.addr == OFS_SER_MODE;
    wire wrBus = busReq.wr && busReq.addr == OFS_SER_BUS;
    wire wrAdr = busReq.wr && busReq.addr == OFS_SLAVE_ADR;
    wire wrShift = busReq.wr && busReq.addr == OFS_SER_SHIFT;
    wire wrFlags = busReq.wr && busReq.addr == OFS_CORE_FLAGS;
    wire wrVecHi = busReq.wr && busReq.addr == OFS_VEC_HI;
    wire wrVecLo = busReq.wr && busReq.addr == OFS_VEC_LO;
    wire enterHalt = wrCtrl && busReq.wdata[CTRL_HALT_BIT] && state_reg == RUN;
    wire enterStop = wrCtrl && busReq.wdata[CTRL_STOP_BIT] && state_reg == RUN;
    wire instrPulse = instrDone || (wrCtrl && busReq.wdata[CTRL_INSTR_BIT]);

    logic wake;
    logic vectorTake;
    logic [7:0] modeQ, busQ, adrQ, shiftQ;

    swrc_wake_logic #(.NSRC(NSRC)) u_wake (
        .irqReq(irqReq_reg),
        .irqEn(irqEn_reg),
        .interrupt_master_enable(ime_reg),
        .wake(wake),
        .vectorTake(vectorTake)
    );

    swrc_regfile u_regs (
        .clk(clk),
        .nrst(nrst),
        .wrMode(wrMode),
        .wrBus(wrBus),
        .wrAdr(wrAdr),
        .wrShift(wrShift),
        .wdata(wdata),
        .serialModeReg(modeQ),
        .serialBusReg(busQ),
        .slaveAdrReg(adrQ),
        .serialShiftReg(shiftQ)
    );

    // ------------------------------------------------------------
    // standby state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            RUN:
                if (enterStop)
                    state_next = STOPPED;
                else if (enterHalt)
                    state_next = HALTED;
            // a request already pending wakes on the very next cycle
            HALTED:
                if (wake) // RULE12 RULE14
                    state_next = vectorTake ? WAKE_WAIT : RUN; // RULE2 RULE4
            // interrupts are ignored here; only nrst leaves stop
            STOPPED:
                state_next = STOPPED; // RULE11
            WAKE_WAIT:
                if (instrCnt_reg == VECTOR_DELAY)
                    state_next = RUN; // RULE3
        endcase
    end

    // ------------------------------------------------------------
    // named next values
    // ------------------------------------------------------------
    // the vector wait still lets the core run its two instructions
    wire runNext = state_next == RUN || state_next == WAKE_WAIT;
    wire [10:0] pcStart = {vecHi_reg, vecLo_reg};
    wire [NSRC-1:0] irqNext = (wrReq ? wdata[NSRC-1:0] : irqReq_reg) | irqSet;
    wire cntClear = state_reg == HALTED && state_next == WAKE_WAIT;
    wire cntStep = state_reg == WAKE_WAIT && instrPulse;
    wire vecDue = state_reg == WAKE_WAIT && instrCnt_reg == VECTOR_DELAY;
    wire standbyNext = state_next == HALTED || state_next == STOPPED;

    // ------------------------------------------------------------
    // reset: same path whatever the state, no stabilisation wait
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            state_reg <= RUN; // RULE1 RULE5
        else
            state_reg <= state_next;
    end

    // no oscillator wait is modelled, so the core starts on the first edge
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            relDone_reg <= 1'b0;
            pcLoad_reg <= 1'b0;
            run_reg <= 1'b0; // RULE5
        end
        else
        begin
            relDone_reg <= 1'b1;
            // first clock after release: load and run at once
            pcLoad_reg <= !relDone_reg; // RULE6 RULE13
            run_reg <= relDone_reg ? runNext : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ime_reg <= 1'b0;
        else if (wrCtrl)
            ime_reg <= wdata[CTRL_IME_BIT];
    end

    // hardware set wins over software clear; flag held on inline wake
    always_ff @(posedge clk)
    begin
        if (!nrst)
            irqReq_reg <= NSRC'(IRQ_RST);
        else
            irqReq_reg <= irqNext; // RULE2
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            irqEn_reg <= NSRC'(IRQ_RST);
        else if (wrEn)
            irqEn_reg <= wdata[NSRC-1:0];
    end

    // ------------------------------------------------------------
    // vector delay after a wake with master enable set
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            instrCnt_reg <= 2'h0;
        else if (cntClear)
            instrCnt_reg <= 2'h0;
        else if (cntStep)
            instrCnt_reg <= instrCnt_reg + 2'h1;
    end

    // one-cycle pulse as the wait hands back to run
    always_ff @(posedge clk)
    begin
        if (!nrst)
            vecReq_reg <= 1'b0;
        else
            vecReq_reg <= vecDue; // RULE3
    end

    // ------------------------------------------------------------
    // core flags
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            skip_reg <= 3'h0; // RULE15
            status_reg <= 1'b0; // RULE15
        end
        else if (wrFlags)
        begin
            skip_reg <= wdata[3:1];
            status_reg <= wdata[4];
        end
    end

    // carry keeps its contents across reset
    always_ff @(posedge clk)
    begin
        if (nrst && wrFlags)
            carry_reg <= wdata[FLAG_CARRY_BIT]; // RULE15
    end

    // ------------------------------------------------------------
    // start address
    // ------------------------------------------------------------
    // vector bytes and pc keep their contents across reset
    always_ff @(posedge clk)
    begin
        if (nrst && wrVecHi)
            vecHi_reg <= wdata[2:0];
        if (nrst && wrVecLo)
            vecLo_reg <= wdata;
    end

    // loaded once, on the first edge after nrst rises
    always_ff @(posedge clk)
    begin
        if (nrst && !relDone_reg)
            pc_reg <= pcStart; // RULE6
    end

    // standby marker sampled while nrst is high and held through reset, read back in the status register only
    always_ff @(posedge clk)
    begin
        if (nrst)
            standby_reg <= standbyNext;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rdMux;
    always_comb
    begin
        unique case (busReq.addr)
            OFS_CTRL: rdMux = {5'h00, state_reg == STOPPED, state_reg == HALTED, ime_reg};
            OFS_STATUS: rdMux = {5'h00, standby_reg, vecReq_reg, run_reg};
            OFS_IRQ_REQ: rdMux = 8'(irqReq_reg);
            OFS_IRQ_EN: rdMux = 8'(irqEn_reg);
            OFS_SER_MODE: rdMux = modeQ;
            OFS_SER_BUS: rdMux = busQ;
            OFS_SLAVE_ADR: rdMux = adrQ;
            OFS_SER_SHIFT: rdMux = shiftQ;
            OFS_PC: rdMux = pc_reg[7:0];
            OFS_CORE_FLAGS: rdMux = {3'h0, status_reg, skip_reg, carry_reg};
            OFS_VEC_HI: rdMux = {5'h00, vecHi_reg};
            OFS_VEC_LO: rdMux = vecLo_reg;
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= busReq.rd ? rdMux : 8'h00;
    end

    // ------------------------------------------------------------
    // core carrier
    // ------------------------------------------------------------
    // wires only: every field is a flip-flop, so outputs stay registered
    swrc_core_t coreOut;

    assign coreOut = '{run: run_reg, vectorReq: vecReq_reg, pc: pc_reg, pcLoad: pcLoad_reg};
    assign rdata = rdata_reg;
    assign coreRun = coreOut.run;
    assign vectorReq = coreOut.vectorReq;
    assign pcLoad = coreOut.pcLoad;
    assign programCounter = coreOut.pc;
endmodule

/* swrc_top_sva.sv */
`timescale 1ns/1ps
// Purpose: port checks of the standby, wake and reset controller
// Assumes: synchronous active-low nrst, one clock
// Notes: bound to swrc_top from the testbench
module swrc_top_sva
    import swrc_pkg::*;
#(
    parameter int NSRC = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // sources and core
    input wire logic [NSRC-1:0] irqSet,
    input wire logic instrDone,
    input wire logic coreRun,
    input wire logic vectorReq,
    input wire logic pcLoad,
    input wire logic [10:0] programCounter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence stopIn;
        wr && addr == OFS_CTRL && wdata[CTRL_STOP_BIT] && coreRun ##2 !coreRun;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_release_loads: assert property ($rose(nrst) |=> pcLoad && coreRun)
        else $error("no start after reset release");
    a_pcload_cause: assert property (pcLoad |-> !$past(nrst, 2))
        else $error("start load without reset");
    a_pcload_single: assert property (pcLoad |=> !pcLoad)
        else $error("start load longer than one cycle");
    a_pc_only_load: assert property ($changed(programCounter) |-> pcLoad)
        else $error("counter moved outside a start load");
    // reset itself must be watched, so no disable here
    a_reset_quiet: assert property (disable iff (1'h0)
        !nrst |=> !coreRun && !pcLoad && !vectorReq)
        else $error("core active during reset");
    a_stop_holds: assert property (stopIn |=> !coreRun [*8])
        else $error("stop left without reset");
    a_vector_pulse: assert property (vectorReq |=> !vectorReq)
        else $error("vector request longer than one cycle");
    a_vector_running: assert property (vectorReq |-> coreRun)
        else $error("vector request while core held");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule

/* swrc_wake_logic.sv */
`timescale 1ns/1ps
// Purpose: combinational wake decision for the halt state
// Assumes: request and enable vectors of equal width
// Notes: pure decode, no state
module swrc_wake_logic
    import swrc_pkg::*;
#(
    parameter int NSRC = 4
)
(
    // interrupt flags
    input wire logic [NSRC-1:0] irqReq,
    input wire logic [NSRC-1:0] irqEn,
    input wire logic interrupt_master_enable,
    // decision
    output logic wake,
    output logic vectorTake
);

    logic [NSRC-1:0] armed;
    logic [NSRC-1:0] vecArmed;

    genvar i;
    generate
        for (i = 0; i < NSRC; i++)
        begin : g_src
            // edge zero cannot release halt
            assign armed[i] = (i == IRQ_EDGE0_BIT) ? 1'b0 : (irqReq[i] & irqEn[i]); // RULE12
            // testable wake input releases but never vectors
            assign vecArmed[i] = (i == IRQ_TWAKE_BIT) ? 1'b0 : armed[i]; // RULE4
        end
    endgenerate

    assign wake = |armed; // RULE14
    assign vectorTake = interrupt_master_enable & (|vecArmed); // RULE2 RULE3
endmodule
